/* File: tsrc_defs.svh */
// Constants for the temperature sensor register core and its host controller.
// Assumes inclusion by bare name from the package and from both ends.
`ifndef TSRC_DEFS_SVH
`define TSRC_DEFS_SVH
`define TSRC_PTR_TEMP 3'h0
`define TSRC_PTR_CFG 3'h1
`define TSRC_PTR_HYST 3'h2
`define TSRC_PTR_OVER 3'h3
`define TSRC_PTR_SHOT 3'h4
`define TSRC_RST_TEMP 16'h0000
`define TSRC_RST_CFG 8'h00
`define TSRC_RST_HYST 16'h4b00
`define TSRC_RST_OVER 16'h5000
`define TSRC_CFG_SHUT 0
`define TSRC_CFG_INT 1
`define TSRC_CFG_POL 2
`define TSRC_CFG_FQLO 3
`define TSRC_CFG_FQHI 4
`define TSRC_CFG_SHOT 5
`define TSRC_CFG_WMASK 8'h3f
`define TSRC_LOW_MASK 16'hfff0
`define TSRC_CONV_MS 60
`define TSRC_CLK_KHZ 100000
`define TSRC_APB_CTRL 12'h000
`define TSRC_APB_WDATA 12'h004
`define TSRC_APB_STAT 12'h008
`define TSRC_APB_RDATA 12'h00c
`define TSRC_CTL_PTRW 8
`define TSRC_CTL_REGW 9
`define TSRC_CTL_REGR 10
`define TSRC_CTL_WIDE 11
`endif

/* File: tsrc_pkg.sv */
// Types used by the host controller; the sensor core uses none of them.
// Assumes tsrc_defs.svh is on the include path.
`include "tsrc_defs.svh"
package tsrc_pkg;
    typedef enum logic [1:0] {TSRC_IDLE, TSRC_WAIT, TSRC_DONE} tsrc_hst_t;
endpackage

/* File: tsrc_if.sv */
// Register link between the host controller and the sensor core.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
interface tsrc_if;
    logic [7:0] ptrValue;
    logic ptrWrite;
    logic [15:0] wrData;
    logic wrTwoBytes;
    logic regWrite;
    logic regRead;
    logic [15:0] rdData;
    logic rdValid;
    modport device (input ptrValue, ptrWrite, wrData, wrTwoBytes, regWrite, regRead,
        output rdData, rdValid);
    modport host (output ptrValue, ptrWrite, wrData, wrTwoBytes, regWrite, regRead,
        input rdData, rdValid);
endinterface

/* File: tsrc_fault_queue.sv */
// Consecutive fault counter for the alert path.
// Assumes resultValid pulses once per completed conversion.
`timescale 1ns/10ps
`include "tsrc_defs.svh"
module tsrc_fault_queue (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Conversion outcome.
    input wire logic resultValid,
    input wire logic isFault,
    input wire logic [1:0] queueSel,
    // Run complete.
    output logic tripped
);
    typedef struct packed {logic [2:0] count;} tsrc_fq_t;
    tsrc_fq_t st, next_st;
    logic [2:0] need;
    always_comb begin
        case (queueSel)
            2'h0: need = 3'h1;
            2'h1: need = 3'h2;
            2'h2: need = 3'h4;
            default: need = 3'h6;
        endcase
        next_st = st;
        if (resultValid) begin
            if (!isFault) begin
                next_st.count = 3'h0;
            end else if (st.count < need) begin
                next_st.count = st.count + 3'h1;
            end else begin
                next_st.count = need;
            end
        end
    end
    assign tripped = (st.count >= need);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

/* File: tsrc_device.sv */
// Sensor register core: pointer, registers, conversion timing and alert.
// Assumes a converter answering convStart with convDone and a 12-bit code.
//
// Added by the designer: the APB register port, which sits in tsrc_host; this core has only the register link.
`timescale 1ns/10ps
`include "tsrc_defs.svh"
module tsrc_device #(
    parameter int CONV_CYCLES = `TSRC_CONV_MS * `TSRC_CLK_KHZ
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Register link.
    tsrc_if.device link,
    // Converter.
    output logic convStart,
    input wire logic convDone,
    input wire logic [11:0] convCode,
    // Alert pin, open drain.
    input wire logic alertIn,
    output logic limitAlertOut,
    output logic limitAlertOe,
    // Power state.
    output logic poweredDown
);
    typedef struct packed {
        logic [2:0] ptr;
        logic [15:0] temp;
        logic [7:0] cfg;
        logic [15:0] hyst;
        logic [15:0] over;
        logic [31:0] timer;
        logic busy;
        logic shotPending;
        logic alert;
        logic [15:0] rdData;
        logic rdValid;
        logic convStart;
        logic pinLow;
        logic down;
    } tsrc_dev_t;
    tsrc_dev_t st, next_st;
    logic tripped;
    logic resultValid;
    logic isFault;
    logic [15:0] newTemp;

    function automatic logic sge(input logic [15:0] a, input logic [15:0] b);
        sge = $signed(a) >= $signed(b);
    endfunction

    assign newTemp = {convCode, 4'h0};
    assign resultValid = convDone && st.busy;
    assign isFault = sge(newTemp, st.over);

    tsrc_fault_queue tsrc_fault_queue_inst (
        .sys_clk(sys_clk),
        .rst(rst),
        .resultValid(resultValid),
        .isFault(isFault),
        .queueSel(st.cfg[`TSRC_CFG_FQHI:`TSRC_CFG_FQLO]),
        .tripped(tripped)
    );

    always_comb begin
        next_st = st;
        next_st.rdValid = 1'b0;
        next_st.convStart = 1'b0;
        if (link.ptrWrite) begin
            next_st.ptr = link.ptrValue[2:0];
            if (link.ptrValue[2:0] == `TSRC_PTR_SHOT) begin
                next_st.shotPending = 1'b1;
            end
        end
        if (link.regWrite) begin
            case (st.ptr)
                `TSRC_PTR_CFG: next_st.cfg = link.wrData[15:8] & `TSRC_CFG_WMASK;
                `TSRC_PTR_HYST: next_st.hyst = link.wrData & `TSRC_LOW_MASK;
                `TSRC_PTR_OVER: next_st.over = link.wrData & `TSRC_LOW_MASK;
                `TSRC_PTR_SHOT: next_st.shotPending = 1'b1;
                default: next_st.temp = st.temp;
            endcase
        end
        if (link.regRead) begin
            next_st.rdValid = 1'b1;
            case (st.ptr)
                `TSRC_PTR_TEMP: next_st.rdData = st.temp;
                `TSRC_PTR_CFG: next_st.rdData = {st.cfg, 8'h00};
                `TSRC_PTR_HYST: next_st.rdData = st.hyst;
                `TSRC_PTR_OVER: next_st.rdData = st.over;
                default: next_st.rdData = 16'h0000;
            endcase
            if (st.cfg[`TSRC_CFG_INT] && !tripped && !isFault) begin
                next_st.alert = 1'b0;
            end
        end
        next_st.down = st.cfg[`TSRC_CFG_SHUT] || st.cfg[`TSRC_CFG_SHOT];
        if (!st.busy) begin
            if (st.cfg[`TSRC_CFG_SHUT] && !st.cfg[`TSRC_CFG_SHOT]) begin
                next_st.timer = '0;
            end else if (st.cfg[`TSRC_CFG_SHOT]) begin
                if (st.shotPending) begin
                    next_st.shotPending = 1'b0;
                    next_st.busy = 1'b1;
                    next_st.convStart = 1'b1;
                    next_st.down = 1'b0;
                end
            end else if (st.timer >= 32'(CONV_CYCLES - 1)) begin
                next_st.timer = '0;
                next_st.busy = 1'b1;
                next_st.convStart = 1'b1;
            end else begin
                next_st.timer = st.timer + 32'h1;
            end
        end else begin
            next_st.down = 1'b0;
            if (!st.cfg[`TSRC_CFG_SHOT]) begin
                next_st.timer = st.timer + 32'h1;
            end
        end
        if (resultValid) begin
            next_st.busy = 1'b0;
            next_st.temp = newTemp;
            if (!sge(newTemp, st.hyst) && !st.cfg[`TSRC_CFG_INT]) begin
                next_st.alert = 1'b0;
            end
        end
        // The queue still shows the old run in the cycle a good result clears it.
        if (tripped && !(resultValid && !isFault)) begin
            next_st.alert = 1'b1;
        end
        next_st.pinLow = st.cfg[`TSRC_CFG_POL] ? !next_st.alert : next_st.alert;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.temp <= `TSRC_RST_TEMP;
            st.cfg <= `TSRC_RST_CFG;
            st.hyst <= `TSRC_RST_HYST;
            st.over <= `TSRC_RST_OVER;
        end else begin
            st <= next_st;
        end
    end

    assign link.rdData = st.rdData;
    assign link.rdValid = st.rdValid;
    assign convStart = st.convStart;
    assign limitAlertOut = 1'b0;
    assign limitAlertOe = st.pinLow;
    assign poweredDown = st.down;
endmodule

/* File: tsrc_host.sv */
// Host controller: APB registers that drive pointer, writes and reads.
// Assumes an APB master; answers every access with pready one cycle later.
`timescale 1ns/10ps
`include "tsrc_defs.svh"
module tsrc_host (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Register link.
    tsrc_if.host link
);
    typedef struct packed {
        tsrc_pkg::tsrc_hst_t state;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [7:0] ptrValue;
        logic ptrWrite;
        logic regWrite;
        logic regRead;
        logic wide;
        logic [15:0] wrData;
    } tsrc_host_t;
    tsrc_host_t st, next_st;
    logic access;
    logic commit;
    assign access = psel && penable && !st.pready;
    assign commit = psel && penable && st.pready;

    always_comb begin
        next_st = st;
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;
        next_st.ptrWrite = 1'b0;
        next_st.regWrite = 1'b0;
        next_st.regRead = 1'b0;
        case (st.state)
            tsrc_pkg::TSRC_WAIT: begin
                if (link.rdValid) begin
                    next_st.rdata = link.rdData;
                    next_st.state = tsrc_pkg::TSRC_IDLE;
                end
            end
            default: next_st.state = tsrc_pkg::TSRC_IDLE;
        endcase
        if (access) begin
            next_st.pready = 1'b1;
            next_st.prdata = 32'h0;
            case (paddr)
                `TSRC_APB_CTRL: next_st.prdata = 32'h0;
                `TSRC_APB_WDATA: next_st.prdata = {16'h0, st.wdata};
                `TSRC_APB_STAT: next_st.prdata = {31'h0, st.state == tsrc_pkg::TSRC_WAIT};
                `TSRC_APB_RDATA: next_st.prdata = {16'h0, st.rdata};
                default: next_st.pslverr = 1'b1;
            endcase
        end
        // Writes land only at the edge that sees pready high, as the master expects.
        if (commit && pwrite) begin
            case (paddr)
                `TSRC_APB_CTRL: begin
                    next_st.ptrValue = pwdata[7:0];
                    next_st.ptrWrite = pwdata[`TSRC_CTL_PTRW];
                    next_st.regWrite = pwdata[`TSRC_CTL_REGW];
                    next_st.regRead = pwdata[`TSRC_CTL_REGR];
                    next_st.wide = pwdata[`TSRC_CTL_WIDE];
                    next_st.wrData = pwdata[`TSRC_CTL_WIDE] ? st.wdata :
                        {st.wdata[15:8] & 8'h3f, 8'h00};
                    if (pwdata[`TSRC_CTL_REGR]) begin
                        next_st.state = tsrc_pkg::TSRC_WAIT;
                    end
                end
                `TSRC_APB_WDATA: next_st.wdata = pwdata[15:0];
                default: next_st.wdata = st.wdata;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign link.ptrValue = st.ptrValue;
    assign link.ptrWrite = st.ptrWrite;
    assign link.regWrite = st.regWrite;
    assign link.regRead = st.regRead;
    assign link.wrData = st.wrData;
    assign link.wrTwoBytes = st.wide;
endmodule

/* File: tsrc_props.sv */
// Checker on the link between host controller and sensor core.
// Assumes one clock and rst active high.
`timescale 1ns/10ps
`include "tsrc_defs.svh"
module tsrc_props (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Link.
    input wire logic [7:0] ptrValue,
    input wire logic ptrWrite,
    input wire logic [15:0] wrData,
    input wire logic wrTwoBytes,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] rdData,
    input wire logic rdValid
);
    // Shadows follow pointer writes and two-byte limit writes, so reads are judged without a converter model.
    logic [2:0] ptr;
    logic [15:0] hyst;
    logic [15:0] over;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ptr <= `TSRC_PTR_TEMP;
            hyst <= `TSRC_RST_HYST;
            over <= `TSRC_RST_OVER;
        end else begin
            if (ptrWrite) ptr <= ptrValue[2:0];
            if (regWrite && wrTwoBytes && ptr == `TSRC_PTR_HYST) hyst <= wrData & `TSRC_LOW_MASK;
            if (regWrite && wrTwoBytes && ptr == `TSRC_PTR_OVER) over <= wrData & `TSRC_LOW_MASK;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_read_answer: assert property (regRead |=> rdValid)
        else $error("read not answered");
    a_answer_cause: assert property (rdValid |-> $past(regRead))
        else $error("answer without read");
    a_data_holds: assert property (!rdValid |-> $stable(rdData))
        else $error("read data moved");
    a_temp_low: assert property
        (rdValid && $past(ptr) == `TSRC_PTR_TEMP |-> rdData[3:0] == 4'h0)
        else $error("temperature low bits set");
    a_cfg_reserved: assert property
        (rdValid && $past(ptr) == `TSRC_PTR_CFG |-> rdData[15:14] == 2'h0)
        else $error("reserved bits set");
    a_hyst_read: assert property
        (rdValid && $past(ptr) == `TSRC_PTR_HYST |-> rdData == hyst)
        else $error("hysteresis readback wrong");
    a_over_read: assert property
        (rdValid && $past(ptr) == `TSRC_PTR_OVER |-> rdData == over)
        else $error("limit readback wrong");
    a_strobe_single: assert property (ptrWrite || regWrite || regRead |=> !(ptrWrite || regWrite))
        else $error("strobe held");
    cover property (rdValid && $past(ptr) == 3'h2);
    cover property (ptrWrite && ptrValue == 8'h04);
    cover property (regWrite && wrTwoBytes);
endmodule

/* File: temp_sensor_register_core_test.sv */
// Bench for host controller and sensor core joined by the link.
// Assumes the design files and tsrc_props are compiled first.
`timescale 1ns/10ps
`include "tsrc_defs.svh"
module temp_sensor_register_core_test;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] r;
    logic pready, pslverr, convStart, limitAlertOut, limitAlertOe, poweredDown, pin, e;
    logic convDone = 1'b0;
    logic [11:0] convCode = 12'h000;
    logic [11:0] code = 12'h000;
    int errors = 0;
    int totalChecks = 0;
    int starts = 0;
    tsrc_if lnk ();
    // The alert pin has a pull-up, so a released pin reads high.
    assign pin = limitAlertOe ? limitAlertOut : 1'b1;
    always #5 sys_clk = ~sys_clk;
    tsrc_host tsrc_host_inst (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .link(lnk));
    tsrc_device #(.CONV_CYCLES(50)) tsrc_device_inst (.sys_clk, .rst, .link(lnk), .convStart,
        .convDone, .convCode, .alertIn(pin), .limitAlertOut, .limitAlertOe, .poweredDown);
    tsrc_props tsrc_props_inst (.sys_clk, .rst, .ptrValue(lnk.ptrValue), .ptrWrite(lnk.ptrWrite),
        .wrData(lnk.wrData), .wrTwoBytes(lnk.wrTwoBytes), .regWrite(lnk.regWrite),
        .regRead(lnk.regRead), .rdData(lnk.rdData), .rdValid(lnk.rdValid));
    // The converter answers four cycles after a start with the current code.
    always @(posedge sys_clk) begin
        if (convStart === 1'b1) begin
            starts <= starts + 1;
            repeat (3) @(posedge sys_clk);
            convCode <= code;
            convDone <= 1'b1;
            @(posedge sys_clk);
            convDone <= 1'b0;
        end
    end
    task automatic wrap_up;
        $display("checks %0d errors %0d", totalChecks, errors);
        if (errors == 0 && totalChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        totalChecks++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            errors++;
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            errors++;
            wrap_up();
        end
    endtask
    task automatic reg_wr(input logic [2:0] p, input logic [15:0] v, input logic two);
        apb(1'b1, `TSRC_APB_CTRL, {23'h0, 1'b1, 5'h00, p});
        apb(1'b1, `TSRC_APB_WDATA, {16'h0, v});
        apb(1'b1, `TSRC_APB_CTRL, {20'h0, two, 3'h2, 8'h00});
    endtask
    task automatic reg_rd(input logic [2:0] p, input logic [15:0] exp, input logic [15:0] m);
        int n = 0;
        apb(1'b1, `TSRC_APB_CTRL, {23'h0, 1'b1, 5'h00, p});
        apb(1'b1, `TSRC_APB_CTRL, 32'h00000400);
        do begin
            apb(1'b0, `TSRC_APB_STAT, 32'h0);
            n++;
        end while (r[0] !== 1'b0 && n < 20);
        if (r[0] !== 1'b0) begin
            errors++;
            wrap_up();
        end
        apb(1'b0, `TSRC_APB_RDATA, 32'h0);
        chk(r[15:0] & m, exp);
    endtask
    task automatic wait_conv(input int k);
        int n = 0;
        while (k > 0 && n < 2000) begin
            @(posedge sys_clk);
            n++;
            if (convDone === 1'b1) k--;
        end
        if (k > 0) begin
            errors++;
            wrap_up();
        end
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic reset_vals;
        reg_rd(3'h0, 16'h0000, 16'hffff);
        reg_rd(3'h1, 16'h0000, 16'hff00);
        reg_rd(3'h2, 16'h4b00, 16'hffff);
        reg_rd(3'h3, 16'h5000, 16'hffff);
        apb(1'b0, 12'h010, 32'h0);
        chk({15'h0, e}, 16'h0001);
    endtask
    task automatic write_back;
        reg_wr(3'h0, 16'hfff0, 1'b1);
        reg_rd(3'h0, 16'h0000, 16'hffff);
        reg_wr(3'h1, 16'h1c00, 1'b0);
        reg_rd(3'h1, 16'h1c00, 16'hff00);
        reg_wr(3'h2, 16'h100f, 1'b1);
        reg_rd(3'h2, 16'h1000, 16'hffff);
        reg_wr(3'h3, 16'h190f, 1'b1);
        reg_rd(3'h3, 16'h1900, 16'hffff);
    endtask
    task automatic fault_queue;
        int need[4] = '{1, 2, 4, 6};
        for (int q = 0; q < 4; q++) begin
            reg_wr(3'h1, {3'h0, q[1:0], 11'h000}, 1'b0);
            wait_conv(1);
            code = 12'h190;
            wait_conv(need[q] - 1);
            chk({15'h0, pin}, 16'h0001);
            wait_conv(1);
            chk({15'h0, pin}, 16'h0000);
            code = 12'h0f0;
            wait_conv(1);
            chk({15'h0, pin}, 16'h0001);
        end
        reg_rd(3'h0, 16'h0f00, 16'hffff);
    endtask
    task automatic int_mode;
        reg_wr(3'h1, 16'h0200, 1'b0);
        code = 12'h190;
        wait_conv(2);
        code = 12'h0f0;
        wait_conv(2);
        chk({15'h0, pin}, 16'h0000);
        reg_rd(3'h1, 16'h0200, 16'hff00);
        chk({15'h0, pin}, 16'h0001);
    endtask
    task automatic polarity;
        reg_wr(3'h1, 16'h0400, 1'b0);
        wait_conv(1);
        chk({15'h0, pin}, 16'h0000);
        code = 12'h190;
        wait_conv(2);
        chk({15'h0, pin}, 16'h0001);
        code = 12'h0f0;
    endtask
    task automatic low_power;
        int s;
        reg_wr(3'h1, 16'h0100, 1'b0);
        repeat (80) @(posedge sys_clk);
        s = starts;
        repeat (200) @(posedge sys_clk);
        chk(16'(starts - s), 16'h0000);
        chk({15'h0, poweredDown}, 16'h0001);
        reg_wr(3'h1, 16'h2000, 1'b0);
        repeat (80) @(posedge sys_clk);
        s = starts;
        code = 12'hc90;
        apb(1'b1, `TSRC_APB_CTRL, 32'h00000104);
        repeat (100) @(posedge sys_clk);
        chk(16'(starts - s), 16'h0001);
        chk({15'h0, poweredDown}, 16'h0001);
        reg_rd(3'h0, 16'hc900, 16'hffff);
        chk(16'((int'(r[15:4]) - 4096) / 16), 16'hffc9);
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        reset_vals();
        write_back();
        fault_queue();
        int_mode();
        polarity();
        low_power();
        wrap_up();
    end
endmodule
